/* logic/adcsq_pkg.sv */
// Purpose: constants for the converter sequencer and its ALU
// Assumes: pclk at 100 MHz
// Notes: byte offsets of the APB register words
package adcsq_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US = 1000;
    localparam int US_CYCLES = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_STEP_US = 50;
    localparam int DELAY_MAX_US = 750;
    localparam int CNT_W = 24;
    localparam int SAMPLE_W = 10;
    localparam int ACC_W = SAMPLE_W + 1;
    localparam int NSAMP_W = 9;
    localparam int MAX_SAMPLES = 256;

    localparam logic [7:0] OFS_SETUP = 8'h00;
    localparam logic [7:0] OFS_DELAY = 8'h04;
    localparam logic [7:0] OFS_WAIT = 8'h08;
    localparam logic [7:0] OFS_RES_HI = 8'h0C;
    localparam logic [7:0] OFS_RES_LO = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;

    // setup word: channel, reference, sample count code, enable
    localparam int SET_CHAN_LSB = 0;
    localparam int SET_REF_BIT = 3;
    localparam int SET_CNT_LSB = 4;
    localparam int SET_EN_BIT = 7;
    // delay word: steps, external trigger, edge, holdoff
    localparam int DLY_STEP_LSB = 0;
    localparam int DLY_EXT_BIT = 4;
    localparam int DLY_EDGE_BIT = 5;
    localparam int DLY_HOLD_BIT = 6;
    // wait word: wait code, bias codes
    localparam int WT_CODE_LSB = 0;
    localparam int WT_BIAS1_LSB = 4;
    localparam int WT_BIAS2_LSB = 6;
    // result high word
    localparam int RH_DATA_LSB = 0;
    localparam int RH_MODE_LSB = 3;
    localparam int RH_SEL_LSB = 5;
    localparam int RH_STAT_BIT = 7;
    localparam int MASK_DONE_BIT = 0;

    localparam logic MASK_RESET = 1'b0;
    localparam logic EDGE_RESET = 1'b1;

    typedef enum logic [1:0] {ADCSQ_NONE = 2'h0, ADCSQ_AVG = 2'h1, ADCSQ_MAX = 2'h2, ADCSQ_MIN = 2'h3} adcsq_mode_e;
    typedef enum logic [1:0] {ADCSQ_RD_AVG = 2'h0, ADCSQ_RD_MIN = 2'h1, ADCSQ_RD_MAX = 2'h2,
        ADCSQ_RD_LAST = 2'h3} adcsq_rdsel_e;

    function automatic int adcsq_wait_us(input logic [3:0] code);
        case (code)
            4'h0: return 20;
            4'h1: return 40;
            4'h2: return 60;
            4'h3: return 80;
            4'h4: return 160;
            4'h5: return 240;
            4'h6: return 320;
            4'h7: return 640;
            4'h8: return 1280;
            4'h9: return 1920;
            4'hA: return 2560;
            4'hB: return 5120;
            4'hC: return 10240;
            4'hD: return 15360;
            default: return 20480;
        endcase
    endfunction

    function automatic logic [NSAMP_W-1:0] adcsq_samples(input logic [2:0] code);
        return (code == 3'h0) ? NSAMP_W'(1) : NSAMP_W'(NSAMP_W'(2) << code);
    endfunction
endpackage

/* logic/adcsq_alu.sv */
// Purpose: running min, max, average and last sample of a cycle
// Assumes: one valid strobe per finished engine conversion
// Notes: average is a pairwise running mean in an 11-bit sum
`timescale 1ns/1ps
`default_nettype none
module adcsq_alu
    import adcsq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic valid,
    input wire logic [SAMPLE_W-1:0] sample,
    input wire logic [1:0] mode,
    output logic [ACC_W-1:0] acc,
    output logic [SAMPLE_W-1:0] min_val,
    output logic [SAMPLE_W-1:0] max_val,
    output logic [SAMPLE_W-1:0] avg_val,
    output logic [SAMPLE_W-1:0] last_val
);
    typedef struct packed {
        logic first;
        logic [ACC_W-1:0] acc;
        logic [SAMPLE_W-1:0] mn;
        logic [SAMPLE_W-1:0] mx;
        logic [SAMPLE_W-1:0] avg;
        logic [SAMPLE_W-1:0] last;
    } adcsq_alu_s;

    adcsq_alu_s s_reg;
    adcsq_alu_s s_next;
    logic [ACC_W-1:0] sum;

    // carry bit keeps the pairwise sum exact
    assign sum = {1'b0, s_reg.avg} + {1'b0, sample};

    always_comb begin
        s_next = s_reg;
        if (clear) begin
            s_next.first = 1'b1;
            s_next.acc = '0;
        end else if (valid) begin
            s_next.first = 1'b0;
            s_next.last = sample;
            // all three figures kept whatever the mode
            s_next.mn = (s_reg.first || sample < s_reg.mn) ? sample : s_reg.mn;
            s_next.mx = (s_reg.first || sample > s_reg.mx) ? sample : s_reg.mx;
            s_next.avg = s_reg.first ? sample : sum[ACC_W-1:1];
            unique case (adcsq_mode_e'(mode))
                ADCSQ_NONE: s_next.acc = {1'b0, sample};
                ADCSQ_AVG: s_next.acc = s_reg.first ? {1'b0, sample} : sum;
                ADCSQ_MAX: s_next.acc = {1'b0, s_next.mx};
                ADCSQ_MIN: s_next.acc = {1'b0, s_next.mn};
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{first: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign acc = s_reg.acc;
    assign min_val = s_reg.mn;
    assign max_val = s_reg.mx;
    assign avg_val = s_reg.avg;
    assign last_val = s_reg.last;

    a_acc_direct: assert property (@(posedge pclk) disable iff (!presetn)
        valid && !clear && mode == ADCSQ_NONE |=> acc == {1'b0, $past(sample)})
        else $error("direct mode did not load the sample");
endmodule
`default_nettype wire

/* logic/adcsq_ctrl.sv */
// Purpose: sequencer, trigger control and APB registers of the converter
// Assumes: engine answers each start with one eng_done pulse
// Notes: APB reads take no wait state; unmapped offsets give pslverr
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module adcsq_ctrl
    import adcsq_pkg::*;
#(
    parameter int CYC_PER_US = US_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigger_input_pin,
    input wire logic input_power_detect,
    input wire logic eng_done,
    input wire logic [SAMPLE_W-1:0] eng_data,
    output logic eng_start,
    output logic [2:0] eng_channel,
    output logic ref_external_sel,
    output logic ref_regulator_en,
    output logic [1:0] bias_one_code,
    output logic [1:0] bias_two_code,
    output logic bias_one_on,
    output logic host_interrupt_pin_n
);
    if (CYC_PER_US < 1 || CYC_PER_US * 20480 >= (1 << CNT_W)) begin : g_chk
        $error("CYC_PER_US out of range");
    end

    localparam logic [CNT_W-1:0] STEP_CYC = CNT_W'(DELAY_STEP_US * CYC_PER_US);

    typedef enum logic [2:0] {S_IDLE = 3'h0, S_ARM = 3'h1, S_DLY = 3'h3, S_CONV = 3'h2,
        S_WAIT = 3'h6, S_DONE = 3'h7} adcsq_st_e;

    typedef struct packed {
        adcsq_st_e st;
        logic [7:0] setup;
        logic [6:0] dly;
        logic [7:0] wt;
        logic [1:0] mode;
        logic [1:0] rdsel;
        logic mask;
        logic en_prev;
        logic status;
        logic int_n;
        logic trig_prev;
        logic start;
        logic [2:0] c_chan;
        logic [NSAMP_W-1:0] c_nsamp;
        logic [1:0] c_mode;
        logic [6:0] c_dly;
        logic [3:0] c_wait;
        logic [CNT_W-1:0] cnt;
        logic [NSAMP_W-1:0] done_n;
        logic [SAMPLE_W-1:0] r_avg;
        logic [SAMPLE_W-1:0] r_min;
        logic [SAMPLE_W-1:0] r_max;
        logic [SAMPLE_W-1:0] r_last;
        logic [31:0] rdata;
        logic err;
    } adcsq_ctrl_s;

    adcsq_ctrl_s s_reg;
    adcsq_ctrl_s s_next;
    logic alu_clear;
    logic [SAMPLE_W-1:0] a_min;
    logic [SAMPLE_W-1:0] a_max;
    logic [SAMPLE_W-1:0] a_avg;
    logic [SAMPLE_W-1:0] a_last;
    logic [SAMPLE_W-1:0] rd_val;
    logic wr_acc;
    logic setup_ph;
    logic mapped;
    logic ext_mode;
    logic trig_active;
    logic trig_edge;
    logic busy;

    adcsq_alu u_alu (
        .pclk(pclk),
        .presetn(presetn),
        .clear(alu_clear),
        .valid(s_reg.st == S_CONV && eng_done),
        .sample(eng_data),
        .mode(s_reg.c_mode),
        .acc(),
        .min_val(a_min),
        .max_val(a_max),
        .avg_val(a_avg),
        .last_val(a_last)
    );

    assign busy = s_reg.st != S_IDLE;
    assign ext_mode = s_reg.c_dly[DLY_EXT_BIT];
    assign trig_active = s_reg.c_dly[DLY_EDGE_BIT] ? trigger_input_pin : ~trigger_input_pin;
    assign trig_edge = (trigger_input_pin != s_reg.trig_prev) && trig_active;
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign mapped = paddr inside {OFS_SETUP, OFS_DELAY, OFS_WAIT, OFS_RES_HI, OFS_RES_LO, OFS_MASK};
    assign alu_clear = s_reg.st == S_IDLE;

    always_comb begin
        unique case (adcsq_rdsel_e'(s_reg.rdsel))
            ADCSQ_RD_AVG: rd_val = s_reg.r_avg;
            ADCSQ_RD_MIN: rd_val = s_reg.r_min;
            ADCSQ_RD_MAX: rd_val = s_reg.r_max;
            ADCSQ_RD_LAST: rd_val = s_reg.r_last;
        endcase
    end

    always_comb begin
        logic go;
        logic [CNT_W-1:0] wcyc;
        go = 1'b0;
        wcyc = CNT_W'(adcsq_wait_us(s_reg.c_wait) * CYC_PER_US);
        s_next = s_reg;
        s_next.start = 1'b0;
        s_next.trig_prev = trigger_input_pin;
        s_next.en_prev = s_reg.setup[SET_EN_BIT];
        // register reads are captured in the setup phase
        if (setup_ph) begin
            s_next.err = !mapped;
            s_next.rdata = '0;
            case (paddr)
                OFS_SETUP: s_next.rdata[7:0] = s_reg.setup;
                OFS_DELAY: s_next.rdata[6:0] = s_reg.dly;
                OFS_WAIT: s_next.rdata[7:0] = s_reg.wt;
                OFS_RES_HI: s_next.rdata[7:0] = {s_reg.status, s_reg.rdsel, s_reg.mode, 1'b0, rd_val[9:8]};
                OFS_RES_LO: s_next.rdata[7:0] = rd_val[7:0];
                OFS_MASK: s_next.rdata[0] = s_reg.mask;
                default: s_next.rdata = '0;
            endcase
        end
        if (wr_acc) begin
            case (paddr)
                OFS_SETUP: s_next.setup = pwdata[7:0];
                OFS_DELAY: s_next.dly = pwdata[6:0];
                OFS_WAIT: s_next.wt = pwdata[7:0];
                OFS_RES_HI: begin
                    // selection and mode stay put while a cycle runs
                    if (!busy) begin
                        s_next.rdsel = pwdata[RH_SEL_LSB +: 2];
                        s_next.mode = pwdata[RH_MODE_LSB +: 2];
                    end
                end
                OFS_MASK: s_next.mask = pwdata[MASK_DONE_BIT];
                default: s_next.err = s_reg.err;
            endcase
        end
        unique case (s_reg.st)
            S_IDLE: begin
                if (s_reg.setup[SET_EN_BIT] && !s_reg.en_prev) begin
                    s_next.st = S_ARM;
                    s_next.status = 1'b1;
                    s_next.int_n = 1'b1;
                    s_next.done_n = '0;
                    // snapshot so a mid-cycle rewrite cannot disturb the run
                    s_next.c_chan = s_reg.setup[SET_CHAN_LSB +: 3];
                    s_next.c_nsamp = adcsq_samples(s_reg.setup[SET_CNT_LSB +: 3]);
                    s_next.c_mode = s_reg.mode;
                    s_next.c_dly = s_reg.dly;
                    s_next.c_wait = s_reg.wt[WT_CODE_LSB +: 4];
                end
            end
            S_ARM: begin
                if (!ext_mode) begin
                    go = 1'b1;
                end else if (trig_edge) begin
                    s_next.st = S_DLY;
                    s_next.cnt = CNT_W'(s_reg.c_dly[DLY_STEP_LSB +: 4]) * STEP_CYC;
                end
            end
            S_DLY: begin
                if (s_reg.cnt != '0) begin
                    s_next.cnt = s_reg.cnt - CNT_W'(1);
                end else if (trig_active) begin
                    go = 1'b1;
                end else begin
                    s_next.st = S_ARM;
                end
            end
            S_CONV: begin
                if (eng_done) begin
                    s_next.done_n = s_reg.done_n + NSAMP_W'(1);
                    if (s_reg.done_n + NSAMP_W'(1) == s_reg.c_nsamp) begin
                        s_next.st = S_DONE;
                    end else begin
                        s_next.st = S_WAIT;
                        s_next.cnt = wcyc;
                    end
                end
            end
            S_WAIT: begin
                if (s_reg.cnt != '0) begin
                    s_next.cnt = s_reg.cnt - CNT_W'(1);
                end else if (!(ext_mode && s_reg.c_dly[DLY_HOLD_BIT])) begin
                    go = 1'b1;
                end else if (trig_active) begin
                    go = 1'b1;
                end else begin
                    s_next.st = S_ARM;
                end
            end
            S_DONE: begin
                // alu took the last sample on the previous edge
                s_next.r_avg = a_avg;
                s_next.r_min = a_min;
                s_next.r_max = a_max;
                s_next.r_last = a_last;
                s_next.status = 1'b0;
                s_next.int_n = s_reg.mask;
                s_next.st = S_IDLE;
            end
            default: s_next.st = S_IDLE;
        endcase
        if (go) begin
            s_next.st = S_CONV;
            s_next.start = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{st: S_IDLE, mask: MASK_RESET, int_n: 1'b1,
                dly: 7'(EDGE_RESET) << DLY_EDGE_BIT, c_nsamp: NSAMP_W'(1), default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pready = psel && penable;
    assign prdata = s_reg.rdata;
    assign pslverr = s_reg.err && psel && penable;
    assign eng_start = s_reg.start;
    assign eng_channel = busy ? s_reg.c_chan : s_reg.setup[SET_CHAN_LSB +: 3];
    assign ref_external_sel = s_reg.setup[SET_REF_BIT];
    assign ref_regulator_en = !s_reg.setup[SET_REF_BIT];
    assign bias_one_code = s_reg.wt[WT_BIAS1_LSB +: 2];
    assign bias_two_code = s_reg.wt[WT_BIAS2_LSB +: 2];
    assign bias_one_on = input_power_detect;
    assign host_interrupt_pin_n = s_reg.int_n;

    a_start_state: assert property (@(posedge pclk) disable iff (!presetn)
        eng_start |-> s_reg.st == S_CONV && s_reg.done_n < s_reg.c_nsamp)
        else $error("start outside conversion");
    a_enable_busy: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.st == S_IDLE && s_reg.setup[SET_EN_BIT] && !s_reg.en_prev) |=> s_reg.status && busy)
        else $error("enable edge did not start a cycle");
    a_busy_status: assert property (@(posedge pclk) disable iff (!presetn)
        busy && s_reg.st != S_ARM |-> s_reg.status)
        else $error("status low while busy");
    a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.st == S_DONE |=> !s_reg.status && (host_interrupt_pin_n == $past(s_reg.mask)))
        else $error("done sequence wrong");
    a_chan_hold: assert property (@(posedge pclk) disable iff (!presetn)
        busy && $past(busy) |-> $stable(eng_channel))
        else $error("channel moved during cycle");
    a_rdsel_lock: assert property (@(posedge pclk) disable iff (!presetn)
        busy |=> $stable(s_reg.rdsel))
        else $error("readout select changed while busy");
    a_single_same: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.st == S_DONE && s_reg.c_nsamp == NSAMP_W'(1)
        |=> s_reg.r_min == s_reg.r_max && s_reg.r_avg == s_reg.r_last && s_reg.r_min == s_reg.r_avg)
        else $error("single sample values differ");
    a_delay_level: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.st == S_DLY && s_reg.cnt == '0 && !trig_active |=> !eng_start ##0 s_reg.st == S_ARM)
        else $error("start without active trigger level");
    a_sample_count: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.st == S_CONV && eng_done && s_reg.done_n + NSAMP_W'(1) == s_reg.c_nsamp |=> s_reg.st == S_DONE)
        else $error("cycle did not end at sample count");
    a_ref_select: assert property (@(posedge pclk) disable iff (!presetn)
        ref_external_sel |-> !ref_regulator_en)
        else $error("regulator on with external reference");

    c_ext_cycle: cover property (@(posedge pclk) disable iff (!presetn)
        s_reg.st == S_DLY ##[1:1000] s_reg.st == S_DONE);
    c_max_count: cover property (@(posedge pclk) disable iff (!presetn)
        s_reg.st == S_DONE && s_reg.c_nsamp == NSAMP_W'(MAX_SAMPLES));
    c_holdoff_rearm: cover property (@(posedge pclk) disable iff (!presetn)
        s_reg.st == S_WAIT ##1 s_reg.st == S_ARM);
    c_int_low: cover property (@(posedge pclk) disable iff (!presetn) $fell(host_interrupt_pin_n));
endmodule
`default_nettype wire

/* verif/adcsq_eng_model.sv */
// Purpose: behavioural converter engine facing the sequencer
// Assumes: one done pulse per start, word taken from queue q
// Notes: slow stretches the conversion; word is junk off the done cycle
`timescale 1ns/1ps
`default_nettype none
module adcsq_eng_model
    import adcsq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic eng_start,
    input wire logic [2:0] eng_channel,
    input wire logic slow,
    output logic eng_done,
    output logic [SAMPLE_W-1:0] eng_data
);
    logic [SAMPLE_W-1:0] q[$];
    logic [2:0] chans[$];
    int n_starts;
    int cnt;
    // edges since the last done pulse, and the shortest gap seen before a start
    int since;
    int min_gap;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            n_starts <= 0;
            since <= 0;
            min_gap <= 32'h000FFFFF;
            eng_done <= 1'b0;
            eng_data <= '0;
        end else begin
            eng_done <= 1'b0;
            // inverted so a stale word never looks valid
            eng_data <= ~eng_data;
            since <= eng_done ? 0 : since + 1;
            if (eng_start) begin
                if (since < min_gap)
                    min_gap <= since;
                cnt <= slow ? 9 : 2;
                n_starts <= n_starts + 1;
                chans.push_back(eng_channel);
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
                if (cnt == 1) begin
                    eng_done <= 1'b1;
                    eng_data <= (q.size() > 0) ? q.pop_front() : SAMPLE_W'(0);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* verif/tb_adc_sequencer_alu_control.sv */
// Purpose: self-checking bench of the converter sequencer
// Assumes: CYC_PER_US of 1 so waits and delays stay short
// Notes: expected readouts come from the pushed sample list
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_adc_sequencer_alu_control;
    import adcsq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig = 1'b0, pwr = 1'b0, slow = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, eng_done, eng_start, ref_ext, ref_reg, bias_on, int_n;
    logic [SAMPLE_W-1:0] eng_data;
    logic [2:0] eng_channel;
    logic [1:0] b1, b2;
    int failures = 0, n_compared = 0, seed = 49959;
    always #5 pclk = ~pclk;
    adcsq_ctrl #(.CYC_PER_US(1)) adcsq_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trigger_input_pin(trig), .input_power_detect(pwr),
        .eng_done(eng_done), .eng_data(eng_data), .eng_start(eng_start), .eng_channel(eng_channel),
        .ref_external_sel(ref_ext), .ref_regulator_en(ref_reg), .bias_one_code(b1),
        .bias_two_code(b2), .bias_one_on(bias_on), .host_interrupt_pin_n(int_n));
    adcsq_eng_model adcsq_eng_model_inst (.pclk(pclk), .presetn(presetn), .eng_start(eng_start),
        .eng_channel(eng_channel), .slow(slow), .eng_done(eng_done), .eng_data(eng_data));
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let register updates of the access edge land
        #1;
    endtask
    task automatic wait_done();
        do
            apb(OFS_RES_HI, 1'b0, '0);
        while (rd[RH_STAT_BIT] !== 1'b0);
    endtask
    function automatic logic [SAMPLE_W-1:0] expect_val(input logic [SAMPLE_W-1:0] s[$], input int sel);
        logic [SAMPLE_W-1:0] mn, mx;
        logic [ACC_W-1:0] av;
        mn = s[0];
        mx = s[0];
        av = {1'b0, s[0]};
        foreach (s[k]) begin
            if (s[k] < mn)
                mn = s[k];
            if (s[k] > mx)
                mx = s[k];
            // carry bit keeps the pair sum exact
            if (k > 0)
                av = (av + s[k]) >> 1;
        end
        case (sel)
            0: return av[SAMPLE_W-1:0];
            1: return mn;
            2: return mx;
            default: return s[s.size()-1];
        endcase
    endfunction
    task automatic end_of_test();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge pclk);
        failures++;
        end_of_test();
    end
    initial begin
        logic [SAMPLE_W-1:0] smp[$];
        logic [31:0] hi;
        logic [2:0] chan;
        logic [1:0] mode, sel;
        logic rf, mk;
        int code, n0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(int_n, 1'b1)
        apb(8'h18, 1'b0, '0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        for (int c = 0; c < 4; c++) begin
            apb(OFS_WAIT, 1'b1, 32'((c << WT_BIAS1_LSB) | ((3 - c) << WT_BIAS2_LSB)));
            `CHK(b1, 2'(c))
            `CHK(b2, 2'(3 - c))
        end
        @(posedge pclk) pwr <= 1'b1;
        #1 `CHK(bias_on, 1'b1)
        @(posedge pclk) pwr <= 1'b0;
        #1 `CHK(bias_on, 1'b0)
        for (int i = 0; i < 6; i++) begin
            chan = 3'($random(seed));
            rf = 1'($random(seed));
            mode = 2'($random(seed));
            sel = 2'($random(seed));
            mk = 1'($random(seed));
            // odd passes need several samples so mid-cycle writes land while busy
            code = (i == 0) ? 0 : (i == 1) ? 7 : 1 + ($unsigned($random(seed)) % 3);
            @(posedge pclk) slow <= 1'($random(seed));
            apb(OFS_MASK, 1'b1, 32'(mk));
            apb(OFS_RES_HI, 1'b1, 32'({sel, mode}) << RH_MODE_LSB);
            apb(OFS_SETUP, 1'b1, 32'({3'(code), rf, chan}));
            `CHK(ref_ext, rf)
            `CHK(ref_reg, ~rf)
            smp.delete();
            for (int k = 0; k < ((code == 0) ? 1 : (2 << code)); k++)
                smp.push_back((i == 2) ? 10'h3FF : 10'($random(seed)));
            adcsq_eng_model_inst.q = smp;
            adcsq_eng_model_inst.chans.delete();
            adcsq_eng_model_inst.min_gap = 32'h000FFFFF;
            n0 = adcsq_eng_model_inst.n_starts;
            repeat (4) @(posedge pclk);
            apb(OFS_SETUP, 1'b1, 32'({3'(code), rf, chan}) | 32'h80);
            @(posedge pclk);
            apb(OFS_RES_HI, 1'b0, '0);
            `CHK(rd[RH_STAT_BIT], 1'b1)
            `CHK(int_n, 1'b1)
            if (i % 2 == 1) begin
                apb(OFS_SETUP, 1'b1, 32'({3'(code), rf, chan ^ 3'h1}));
                apb(OFS_RES_HI, 1'b1, 32'({~sel, ~mode}) << RH_MODE_LSB);
            end
            wait_done();
            `CHK(adcsq_eng_model_inst.n_starts - n0, smp.size())
            foreach (adcsq_eng_model_inst.chans[k])
                `CHK(adcsq_eng_model_inst.chans[k], chan)
            // wait code 0 is 20 us, one cycle per us here
            `CHK(adcsq_eng_model_inst.min_gap >= 20, 1'b1)
            `CHK(int_n, mk)
            `CHK(rd[6:5], sel)
            `CHK(rd[4:3], mode)
            for (int s = 0; s < 4; s++) begin
                apb(OFS_RES_HI, 1'b1, 32'({2'(s), mode}) << RH_MODE_LSB);
                apb(OFS_RES_HI, 1'b0, '0);
                hi = rd;
                apb(OFS_RES_LO, 1'b0, '0);
                `CHK({hi[1:0], rd[7:0]}, expect_val(smp, s))
            end
        end
        apb(OFS_DELAY, 1'b1, 32'h31);
        apb(OFS_SETUP, 1'b1, 32'h02);
        adcsq_eng_model_inst.q = {10'h155};
        n0 = adcsq_eng_model_inst.n_starts;
        apb(OFS_SETUP, 1'b1, 32'h82);
        @(posedge pclk) trig <= 1'b1;
        repeat (5) @(posedge pclk);
        trig <= 1'b0;
        repeat (80) @(posedge pclk);
        `CHK(adcsq_eng_model_inst.n_starts, n0)
        @(posedge pclk) trig <= 1'b1;
        wait_done();
        `CHK(adcsq_eng_model_inst.n_starts, n0 + 1)
        apb(OFS_RES_LO, 1'b0, '0);
        `CHK(rd[7:0], 8'h55)
        end_of_test();
    end
endmodule
`default_nettype wire
